// [hdl/reference_bias_enable_control.sv]
/*
 * Enable logic for the internal voltage reference, the bandgap generator,
 * the oscillator bias generator and the reference bias generator, with the
 * reference control register on the special-function bus.
 * Assumes all request inputs come from logic on mclk; reads return one
 * cycle after the read strobe.
 */
`timescale 1ns/10ps

module reference_bias_enable_control
    import refbias_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic [SFR_ADDR_W-1:0] sfr_addr,
    input  wire logic [SFR_DATA_W-1:0] sfr_wdata,
    input  wire logic                  sfr_wr,
    input  wire logic                  sfr_rd,
    output logic      [SFR_DATA_W-1:0] sfr_rdata,
    input  wire logic                  converter_enable_bit,
    input  wire logic                  ref_source_select,
    input  wire logic                  osc_enable,
    input  wire logic                  current_output_dac_zero_en,
    input  wire logic                  current_output_dac_one_en,
    input  wire logic                  clock_mult_enable,
    output logic                       int_ref_enable,
    output logic                       ext_ref_selected,
    output logic                       ref_pin_drive,
    output logic                       bandgap_enable,
    output logic                       osc_bias_enable,
    output logic                       ref_bias_enable
);

    // ------------------------------------------------------------------
    // register access
    // ------------------------------------------------------------------
    logic      ctrl_hit;
    logic      ctrl_wr;
    sfr_byte_t ctrl_value;
    logic      bandgap_force_on;
    logic      osc_bias_force_on;

    assign ctrl_hit = (sfr_addr == REF_CTRL_ADDR);
    assign ctrl_wr  = sfr_wr & ctrl_hit;

    masked_sfr_reg #(
        .WIDTH      (SFR_DATA_W),
        .RESET_VAL  (REF_CTRL_RESET),
        .WRITE_MASK (REF_CTRL_WR_MASK)
    ) u_ctrl (
        .mclk    (mclk),
        .resetn  (resetn),
        .wr_en   (ctrl_wr),
        .wr_data (sfr_wdata),
        .value   (ctrl_value)
    );

    assign bandgap_force_on  = ctrl_value[BANDGAP_FORCE_BIT];
    assign osc_bias_force_on = ctrl_value[OSC_BIAS_FORCE_BIT];

    logic [SFR_DATA_W-1:0] sfr_rdata_reg;

    // unmapped addresses read as zero so other slaves can be or-ed in
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sfr_rdata_reg <= '0;
        end else if (sfr_rd && ctrl_hit) begin
            sfr_rdata_reg <= ctrl_value & REF_CTRL_WR_MASK;
        end else begin
            sfr_rdata_reg <= '0;
        end
    end

    assign sfr_rdata = sfr_rdata_reg;

    // ------------------------------------------------------------------
    // enable decisions, evaluated combinationally then registered
    // ------------------------------------------------------------------
    logic int_ref_next;
    logic bandgap_next;
    logic osc_bias_next;
    logic ref_bias_next;

    // a one-cycle register stage keeps analog enables glitch free; the
    // cost is one mclk of lag, far below any analog turn-on time
    always_comb begin
        int_ref_next  = converter_enable_bit
                        && (ref_source_select == REF_SEL_INTERNAL);
        osc_bias_next = osc_enable || osc_bias_force_on;
        bandgap_next  = bandgap_force_on || converter_enable_bit
                        || current_output_dac_zero_en
                        || current_output_dac_one_en
                        || clock_mult_enable || int_ref_next;
        ref_bias_next = bandgap_next || osc_bias_next;
    end

    logic int_ref_enable_reg;
    logic ext_ref_selected_reg;
    logic ref_pin_drive_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ext_ref_selected_reg <= 1'b0;
        end else begin
            ext_ref_selected_reg <= (ref_source_select == REF_SEL_EXTERNAL);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            int_ref_enable_reg <= 1'b0;
            ref_pin_drive_reg  <= 1'b0;
        end else begin
            int_ref_enable_reg <= int_ref_next;
            ref_pin_drive_reg  <= int_ref_next;
        end
    end

    logic bandgap_enable_reg;
    logic osc_bias_enable_reg;
    logic ref_bias_enable_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bandgap_enable_reg  <= 1'b0;
            osc_bias_enable_reg <= 1'b0;
            ref_bias_enable_reg <= 1'b0;
        end else begin
            bandgap_enable_reg  <= bandgap_next;
            osc_bias_enable_reg <= osc_bias_next;
            ref_bias_enable_reg <= ref_bias_next;
        end
    end

    assign int_ref_enable   = int_ref_enable_reg;
    assign ext_ref_selected = ext_ref_selected_reg;
    assign ref_pin_drive    = ref_pin_drive_reg;
    assign bandgap_enable   = bandgap_enable_reg;
    assign osc_bias_enable  = osc_bias_enable_reg;
    assign ref_bias_enable  = ref_bias_enable_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_ref_select_map: assert property (
        @(posedge mclk) disable iff (!resetn)
        ##1 (ext_ref_selected == $past(ref_source_select)))
        else $error("reference select output does not follow select bit");

    a_int_ref_gate: assert property (
        @(posedge mclk) disable iff (!resetn)
        (converter_enable_bit && !ref_source_select) |=> int_ref_enable)
        else $error("internal reference not on when converter uses it");

    a_int_ref_off: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!converter_enable_bit || ref_source_select) |=> !int_ref_enable)
        else $error("internal reference on without a converter need");

    a_osc_bias_auto: assert property (
        @(posedge mclk) disable iff (!resetn)
        osc_enable |=> osc_bias_enable)
        else $error("oscillator bias off while oscillator runs");

    a_osc_bias_force: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ctrl_wr && sfr_wdata[OSC_BIAS_FORCE_BIT]) |=> ##1 osc_bias_enable)
        else $error("oscillator bias force-on bit has no effect");

    a_osc_bias_idle: assert property (
        @(posedge mclk) disable iff (!resetn)
        (!osc_enable && !osc_bias_force_on) |=> !osc_bias_enable)
        else $error("oscillator bias on without cause");

    a_bandgap_users: assert property (
        @(posedge mclk) disable iff (!resetn)
        (current_output_dac_zero_en || current_output_dac_one_en
         || clock_mult_enable || converter_enable_bit || bandgap_force_on)
        |=> bandgap_enable)
        else $error("bandgap off while a user requests it");

    a_ref_bias_need: assert property (
        @(posedge mclk) disable iff (!resetn)
        (bandgap_enable || osc_bias_enable) |-> ref_bias_enable)
        else $error("reference bias off while a generator needs it");

    a_pin_drive: assert property (
        @(posedge mclk) disable iff (!resetn)
        ref_pin_drive == int_ref_enable)
        else $error("reference pin drive disagrees with internal reference");

    a_ctrl_upper_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        (sfr_rd && ctrl_hit) |=> (sfr_rdata[SFR_DATA_W-1:2] == 6'h00))
        else $error("reserved control bits read non-zero");

    a_ctrl_readback: assert property (
        @(posedge mclk) disable iff (!resetn)
        (ctrl_wr ##1 (sfr_rd && ctrl_hit && !sfr_wr))
        |=> (sfr_rdata == ($past(sfr_wdata, 2) & REF_CTRL_WR_MASK)))
        else $error("control register read back differs from write");

endmodule

// [pkg/refbias_pkg.sv]
/*
 * Constants for the reference and bias enable block: the special-function
 * register address, field positions, write mask and reset value.
 * Assumes a single system clock domain and an 8-bit special-function bus.
 */
package refbias_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REF_CTRL_ADDR     = 8'hD1;
    localparam logic [7:0] REF_CTRL_RESET    = 8'h00;
    localparam logic [7:0] REF_CTRL_WR_MASK  = 8'h03;

    // ------------------------------------------------------------------
    // field positions inside the reference control register
    // ------------------------------------------------------------------
    localparam int BANDGAP_FORCE_BIT  = 0;
    localparam int OSC_BIAS_FORCE_BIT = 1;

    // ------------------------------------------------------------------
    // converter reference select encoding
    // ------------------------------------------------------------------
    localparam logic REF_SEL_INTERNAL = 1'b0;
    localparam logic REF_SEL_EXTERNAL = 1'b1;

    // ------------------------------------------------------------------
    // bus geometry and read timing
    // ------------------------------------------------------------------
    localparam int SFR_ADDR_W   = 8;
    localparam int SFR_DATA_W   = 8;
    localparam int READ_LATENCY = 1;

    typedef logic [SFR_DATA_W-1:0] sfr_byte_t;

endpackage

// [hdl/masked_sfr_reg.sv]
/*
 * One special-function register of generic width with a per-bit write mask.
 * Bits outside the mask never change and read back as zero.
 * Assumes the write strobe is already qualified by the address decode.
 */
`timescale 1ns/10ps

module masked_sfr_reg
    import refbias_pkg::*;
#(
    parameter int               WIDTH      = SFR_DATA_W,
    parameter logic [WIDTH-1:0] RESET_VAL  = REF_CTRL_RESET,
    parameter logic [WIDTH-1:0] WRITE_MASK = REF_CTRL_WR_MASK
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] value
);

    logic [WIDTH-1:0] value_reg;
    logic [WIDTH-1:0] value_next;

    // ------------------------------------------------------------------
    // merge: masked bits take the bus, others keep (and stay zero)
    // ------------------------------------------------------------------
    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = (wr_data & WRITE_MASK) | (value_reg & ~WRITE_MASK);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next & WRITE_MASK;
        end
    end

    assign value = value_reg;

endmodule

// [verif/tb.sv]
/*
 * Self-checking bench for the reference and bias enable block: random
 * register traffic and enable levels, compared every cycle with a model.
 * Assumes the design carries its own assertions; one clock, mclk.
 */
`timescale 1ns/10ps

module tb
    import refbias_pkg::*;
;
    logic                  mclk;
    logic                  resetn;
    logic [SFR_ADDR_W-1:0] sfr_addr;
    logic [SFR_DATA_W-1:0] sfr_wdata;
    logic                  sfr_wr;
    logic                  sfr_rd;
    logic [SFR_DATA_W-1:0] sfr_rdata;
    logic [5:0]            en_in;
    logic [5:0]            flags_out;
    logic [31:0]           lfsr_state;
    logic                  started;
    int                    model_reg;
    int                    exp_rdata;
    int                    exp_flags;
    int                    failures;
    int                    num_checks;

    reference_bias_enable_control reference_bias_enable_control_inst (
        .mclk                       (mclk),
        .resetn                     (resetn),
        .sfr_addr                   (sfr_addr),
        .sfr_wdata                  (sfr_wdata),
        .sfr_wr                     (sfr_wr),
        .sfr_rd                     (sfr_rd),
        .sfr_rdata                  (sfr_rdata),
        .converter_enable_bit       (en_in[0]),
        .ref_source_select          (en_in[1]),
        .osc_enable                 (en_in[2]),
        .current_output_dac_zero_en (en_in[3]),
        .current_output_dac_one_en  (en_in[4]),
        .clock_mult_enable          (en_in[5]),
        .int_ref_enable             (flags_out[0]),
        .ext_ref_selected           (flags_out[1]),
        .ref_pin_drive              (flags_out[2]),
        .bandgap_enable             (flags_out[3]),
        .osc_bias_enable            (flags_out[4]),
        .ref_bias_enable            (flags_out[5])
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        num_checks++;
        if (seen !== expected) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // cycle model: outputs follow the inputs sampled one edge earlier
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        int ir;
        int bg;
        int ob;
        if (resetn !== 1'b1) begin
            model_reg = 0;
            exp_rdata = 0;
            exp_flags = 0;
        end else begin
            ir = (en_in[0] && !en_in[1]) ? 1 : 0;
            bg = model_reg[0] | en_in[0] | en_in[3] | en_in[4] | en_in[5] | ir;
            ob = model_reg[1] | en_in[2];
            exp_flags = ir | (en_in[1] << 1) | (ir << 2) | (bg << 3) | (ob << 4)
                        | ((bg | ob) << 5);
            // old value is read, so a read right after a write sees the write
            exp_rdata = (sfr_rd && sfr_addr == REF_CTRL_ADDR) ? model_reg : 0;
            if (sfr_wr && sfr_addr == REF_CTRL_ADDR) begin
                model_reg = sfr_wdata & 8'h03;
            end
        end
    end

    // outputs are settled by the falling edge
    always @(negedge mclk) begin
        if (started) begin
            check(sfr_rdata, 8'(exp_rdata));
            check(8'(flags_out[0]), 8'(exp_flags[0]));
            check(8'(flags_out[1]), 8'(exp_flags[1]));
            check(8'(flags_out[2]), 8'(exp_flags[2]));
            check(8'(flags_out[3]), 8'(exp_flags[3]));
            check(8'(flags_out[4]), 8'(exp_flags[4]));
            check(8'(flags_out[5]), 8'(exp_flags[5]));
        end
    end

    // ------------------------------------------------------------------
    // stimulus: random traffic with a reset in mid-run
    // ------------------------------------------------------------------
    initial begin
        started    = 1'b0;
        failures   = 0;
        num_checks = 0;
        lfsr_state = 32'h00000006;
        resetn     = 1'b0;
        sfr_addr   = 8'h00;
        sfr_wdata  = 8'h00;
        sfr_wr     = 1'b0;
        sfr_rd     = 1'b0;
        en_in      = 6'h00;
        @(posedge mclk);
        started = 1'b1;
        repeat (2) @(posedge mclk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            // inputs stay quiet around the second reset so release is clean
            resetn = !(i >= 1500 && i < 1503);
            if (i >= 1500 && i < 1504) begin
                sfr_wr = 1'b0;
                sfr_rd = 1'b0;
                en_in  = 6'h00;
            end else begin
                // strobes come from untapped bits: after a write on bits 28..27
                // bit 27 is always clear again, so a write could never follow it
                sfr_wr    = (lfsr_state[28:27] == 2'h1);
                sfr_rd    = (lfsr_state[28:27] == 2'h2);
                sfr_addr  = (lfsr_state[4:2] == 3'h0) ? lfsr_state[12:5] : REF_CTRL_ADDR;
                sfr_wdata = lfsr_state[20:13];
                en_in     = lfsr_state[26:21];
            end
            @(posedge mclk);
            #1;
        end
        end_of_test();
    end
endmodule
